/* design/ufc_cfg.svh */
// Constants for the UART FIFO control and DMA ready block
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

// ----------------------------------------------------------------
// Queue sizing
// ----------------------------------------------------------------
`define UFC_QUEUE_DEPTH   16
`define UFC_HOLD_LIMIT    5'h01

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UFC_OFS_DATA      8'h00
`define UFC_OFS_FIFO_CTL  8'h04
`define UFC_OFS_STATUS    8'h08
`define UFC_OFS_INT_STAT  8'h0C
`define UFC_OFS_INT_MASK  8'h10

// ----------------------------------------------------------------
// fifo_control fields and reset value
// ----------------------------------------------------------------
`define UFC_FC_RESET      8'h00
`define UFC_FC_ENABLE     0
`define UFC_FC_RX_CLEAR   1
`define UFC_FC_TX_CLEAR   2
`define UFC_FC_DMA_MODE   3
`define UFC_FC_THR_LO     6
`define UFC_FC_THR_HI     7
`define UFC_FC_KEEP_MASK  8'hC9
`define UFC_FC_PULSE_MASK 8'h06

// ----------------------------------------------------------------
// Receive fill thresholds, in characters
// ----------------------------------------------------------------
`define UFC_THR_SEL0      1
`define UFC_THR_SEL1      4
`define UFC_THR_SEL2      8
`define UFC_THR_SEL3      14

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define UFC_EV_W          4
`define UFC_EV_RX_THR     0
`define UFC_EV_RX_TMO     1
`define UFC_EV_TX_EMPTY   2
`define UFC_EV_RX_OVF     3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define UFC_ST_RX_CNT_LO  0
`define UFC_ST_TX_CNT_LO  8
`define UFC_ST_FIFO_EN    16
`define UFC_ST_TX_RDY_N   17
`define UFC_ST_RX_RDY_N   18
`define UFC_ST_RX_REQ     19
`define UFC_RX_VALID_BIT  8

`endif

/* design/ufc_pkg.sv */
// Types shared by the UART FIFO control modules
package ufc_pkg;

	// One serial character
	typedef logic [7:0] ufc_char_t;

	// DMA signalling modes
	typedef enum logic {
		UFC_DMA_MODE0 = 1'b0,
		UFC_DMA_MODE1 = 1'b1
	} ufc_dma_mode_t;

endpackage

/* design/ufc_q_if.sv */
// Interface between a character queue and its users
`timescale 1ns/1ps

interface ufc_q_if #(
	parameter int CW = 5
);
	import ufc_pkg::*;

	// Fill and drain side
	logic            push;
	ufc_char_t       push_data;
	logic            pop;
	ufc_char_t       pop_data;
	logic            clear;

	// Fill state
	logic [CW-1:0]   count;
	logic            full;
	logic            empty;

	modport queue (
		input  push, push_data, pop, clear,
		output pop_data, count, full, empty
	);

	modport user (
		output push, push_data, pop, clear,
		input  pop_data, count, full, empty
	);

	modport mon (
		input  count, full, empty
	);
endinterface

/* design/ufc_queue.sv */
// Character queue with a run-time depth limit
`timescale 1ns/1ps
`include "ufc_cfg.svh"

module ufc_queue #(
	parameter int DEPTH = `UFC_QUEUE_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Number of usable locations
	input  wire logic [CW-1:0] limit_i,
	// Queue port
	ufc_q_if.queue             q
);
	import ufc_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	ufc_char_t         mem [DEPTH];
	logic [AW-1:0]     wr_ptr;
	logic [AW-1:0]     rd_ptr;
	logic [CW-1:0]     count;

	wire logic         do_push;
	wire logic         do_pop;

	// Pointer advance with wrap
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// Handshake and fill state
	assign do_push    = q.push & ~q.full;
	assign do_pop     = q.pop & ~q.empty;
	assign q.full     = (count >= limit_i);
	assign q.empty    = (count == '0);
	assign q.count    = count;
	assign q.pop_data = mem[rd_ptr];

	// Pointers and count; clear empties the queue only
	always_ff @(posedge clk_i) begin
		if (rst_i || q.clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= bump(wr_ptr);
			if (do_pop)
				rd_ptr <= bump(rd_ptr);
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end

	// Storage
	always_ff @(posedge clk_i) begin
		if (do_push)
			mem[wr_ptr] <= q.push_data;
	end
endmodule

/* design/ufc_ready.sv */
// DMA ready pin generation for transmit and receive
`timescale 1ns/1ps

module ufc_ready (
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Mode selection
	input  wire logic            fifo_en_i,
	input  wire ufc_pkg::ufc_dma_mode_t dma_mode_i,
	// Receive events
	input  wire logic            rx_thr_hit_i,
	input  wire logic            rx_timeout_i,
	// Queue fill state
	ufc_q_if.mon                 tx,
	ufc_q_if.mon                 rx,
	// Ready pins, active low
	output logic                 tx_dma_ready_n_o,
	output logic                 rx_dma_ready_n_o
);
	import ufc_pkg::*;

	logic          rx_armed;
	wire logic     block_mode;
	wire logic     rx_set;
	wire logic     next_rx_armed;
	wire logic     next_tx_ready_n;
	wire logic     next_rx_ready_n;

	// Block mode needs FIFOs on and mode 1
	assign block_mode = fifo_en_i & (dma_mode_i == UFC_DMA_MODE1);

	// RULE_09: latch low on threshold or timeout, release when empty
	assign rx_set        = rx_thr_hit_i | (rx_timeout_i & ~rx.empty);
	assign next_rx_armed = block_mode & (rx_set | (rx_armed & ~rx.empty));

	// RULE_06: mode 0 transmit low while nothing held
	// RULE_08: mode 1 transmit high only when full
	assign next_tx_ready_n = block_mode ? tx.full : ~tx.empty;

	// RULE_07: mode 0 receive low while a character held
	assign next_rx_ready_n = block_mode ? ~next_rx_armed : rx.empty;

	// Pin and latch registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_armed         <= 1'b0;
			tx_dma_ready_n_o <= 1'b0;
			rx_dma_ready_n_o <= 1'b1;
		end else begin
			rx_armed         <= next_rx_armed;
			tx_dma_ready_n_o <= next_tx_ready_n;
			rx_dma_ready_n_o <= next_rx_ready_n;
		end
	end
endmodule

/* design/ufc_top.sv */
// UART channel FIFO control, DMA ready pins and register slave
//
// What this block does
// RULE_01: Control bits 7:6 pick threshold 1/4/8/14.
// RULE_02: Raise receive request when count reaches threshold.
// RULE_03: Receive keeps filling until queue full.
// RULE_04: Control bits 5:4 unused, zero after reset.
// RULE_05: Control bit 3 picks DMA mode, default 0.
// RULE_06: Mode 0 transmit ready low while nothing held.
// RULE_07: Mode 0 receive ready low while data held.
// RULE_08: Mode 1 transmit ready high only when full.
// RULE_09: Mode 1 receive ready: threshold/timeout, till empty.
// RULE_10: Bit 2 clears transmit queue, self-clearing.
// RULE_11: Bit 1 clears receive queue, self-clearing.
// RULE_12: Bit 0 low uses single-character holding registers.
// RULE_13: Receive request drops below threshold.
// RULE_14: Bit 0 high enables both queues.
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ufc_cfg.svh"

module ufc_top #(
	parameter int DEPTH = `UFC_QUEUE_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone classic slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	// Transmitter side
	input  wire logic                tx_pop_i,
	output ufc_pkg::ufc_char_t       tx_data_o,
	output logic                     tx_valid_o,
	output logic [CW-1:0]            tx_count_o,
	// Receiver side
	input  wire logic                rx_push_i,
	input  wire ufc_pkg::ufc_char_t  rx_data_i,
	input  wire logic                rx_timeout_i,
	output logic [CW-1:0]            rx_count_o,
	// Requests and pins
	output logic                     rx_irq_req_o,
	output logic                     tx_dma_ready_n_o,
	output logic                     rx_dma_ready_n_o,
	output logic                     irq_o
);
	import ufc_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]            fifo_control;
	logic                  en_d;
	logic                  en_flip;
	logic                  wb_ack;
	logic                  rd_had_data;
	logic                  rx_req_d;
	logic                  tx_empty_d;
	logic [`UFC_EV_W-1:0]  int_stat;
	logic [`UFC_EV_W-1:0]  int_mask;

	wire logic             bus_req;
	wire logic             bus_do;
	wire logic             bus_wr;
	wire logic             bus_rd;
	wire logic             lane0;
	wire logic             hit_data;
	wire logic             hit_fc;
	wire logic             hit_stat;
	wire logic             hit_istat;
	wire logic             hit_imask;
	wire logic             fifo_en;
	wire ufc_dma_mode_t    dma_mode;
	wire logic [1:0]       thr_sel;
	wire logic [CW-1:0]    rx_fill_threshold;
	wire logic [CW-1:0]    q_limit;
	wire logic             rx_req;
	wire logic [`UFC_EV_W-1:0] events;
	wire logic [`UFC_EV_W-1:0] w1c;
	wire logic [31:0]      status_word;
	wire logic [31:0]      rx_word;
	wire logic [31:0]      rd_word;

	ufc_q_if #(.CW(CW)) txq ();
	ufc_q_if #(.CW(CW)) rxq ();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// RULE_01: threshold select decode
	function automatic logic [CW-1:0] thr_decode(input logic [1:0] sel);
		case (sel)
			2'b00:   thr_decode = CW'(`UFC_THR_SEL0);
			2'b01:   thr_decode = CW'(`UFC_THR_SEL1);
			2'b10:   thr_decode = CW'(`UFC_THR_SEL2);
			2'b11:   thr_decode = CW'(`UFC_THR_SEL3);
			default: thr_decode = CW'(`UFC_THR_SEL0);
		endcase
	endfunction

	// Zero-extend a count into a byte field
	function automatic logic [7:0] cnt_byte(input logic [CW-1:0] c);
		cnt_byte = 8'(c);
	endfunction

	// ----------------------------------------------------------------
	// Wishbone decode
	// ----------------------------------------------------------------

	// Request, commit edge and address hits
	assign bus_req   = wb_cyc_i & wb_stb_i;
	assign bus_do    = bus_req & wb_ack;
	assign bus_wr    = bus_do & wb_we_i;
	assign bus_rd    = bus_do & ~wb_we_i;
	assign lane0     = wb_sel_i[0];
	assign hit_data  = (wb_adr_i == `UFC_OFS_DATA);
	assign hit_fc    = (wb_adr_i == `UFC_OFS_FIFO_CTL);
	assign hit_stat  = (wb_adr_i == `UFC_OFS_STATUS);
	assign hit_istat = (wb_adr_i == `UFC_OFS_INT_STAT);
	assign hit_imask = (wb_adr_i == `UFC_OFS_INT_MASK);

	// Ack one cycle after request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack <= 1'b0;
		else
			wb_ack <= bus_req & ~wb_ack;
	end
	assign wb_ack_o = wb_ack;

	// ----------------------------------------------------------------
	// FIFO control register
	// ----------------------------------------------------------------

	// Field views
	assign fifo_en  = fifo_control[`UFC_FC_ENABLE];
	assign dma_mode = ufc_dma_mode_t'(fifo_control[`UFC_FC_DMA_MODE]);
	assign thr_sel  = fifo_control[`UFC_FC_THR_HI:`UFC_FC_THR_LO];

	// RULE_04: bits 5:4 never stored, reset zero
	// RULE_05: bit 3 stored, mode 0 after reset
	// RULE_10: bit 2 kept one cycle, then self-clears
	// RULE_11: bit 1 kept one cycle, then self-clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_control <= `UFC_FC_RESET;
		end else if (bus_wr && hit_fc && lane0) begin
			fifo_control <= wb_dat_i[7:0]
			                & (`UFC_FC_KEEP_MASK | `UFC_FC_PULSE_MASK);
		end else begin
			fifo_control[`UFC_FC_TX_CLEAR] <= 1'b0;
			fifo_control[`UFC_FC_RX_CLEAR] <= 1'b0;
		end
	end

	// Toggling the enable flushes both queues
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_d    <= 1'b0;
			en_flip <= 1'b0;
		end else begin
			en_d    <= fifo_en;
			en_flip <= 1'b0;
			if (en_d != fifo_en)
				en_flip <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------

	// RULE_12: disabled queues act as one-character holding registers
	// RULE_14: enabled queues use every location
	assign q_limit = fifo_en ? CW'(DEPTH) : CW'(`UFC_HOLD_LIMIT);

	// Transmit queue: bus writes fill, transmitter drains
	// RULE_10: flush transmit queue only, shifter untouched
	assign txq.push      = bus_wr & hit_data & lane0;
	assign txq.push_data = wb_dat_i[7:0];
	assign txq.pop       = tx_pop_i;
	assign txq.clear     = fifo_control[`UFC_FC_TX_CLEAR] | en_flip;

	// Receive queue: receiver fills, bus reads drain
	// RULE_03: writes continue past threshold until full
	// RULE_11: flush receive queue only, shifter untouched
	assign rxq.push      = rx_push_i;
	assign rxq.push_data = rx_data_i;
	assign rxq.pop       = bus_rd & hit_data & rd_had_data;
	assign rxq.clear     = fifo_control[`UFC_FC_RX_CLEAR] | en_flip;

	ufc_queue #(
		.DEPTH   (DEPTH),
		.CW      (CW)
	) u_txq (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.limit_i (q_limit),
		.q       (txq.queue)
	);

	ufc_queue #(
		.DEPTH   (DEPTH),
		.CW      (CW)
	) u_rxq (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.limit_i (q_limit),
		.q       (rxq.queue)
	);

	assign tx_data_o  = txq.pop_data;
	assign tx_valid_o = ~txq.empty;
	assign tx_count_o = txq.count;
	assign rx_count_o = rxq.count;

	// ----------------------------------------------------------------
	// Receive request and DMA pins
	// ----------------------------------------------------------------

	// RULE_01: active threshold, one character when disabled
	assign rx_fill_threshold = fifo_en ? thr_decode(thr_sel)
	                                   : CW'(`UFC_THR_SEL0);

	// RULE_02: request rises when count reaches threshold
	// RULE_13: request drops when count falls below it
	assign rx_req       = (rxq.count >= rx_fill_threshold);
	assign rx_irq_req_o = rx_req;

	ufc_ready u_ready (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.fifo_en_i        (fifo_en),
		.dma_mode_i       (dma_mode),
		.rx_thr_hit_i     (rx_req),
		.rx_timeout_i     (rx_timeout_i),
		.tx               (txq.mon),
		.rx               (rxq.mon),
		.tx_dma_ready_n_o (tx_dma_ready_n_o),
		.rx_dma_ready_n_o (rx_dma_ready_n_o)
	);

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------

	// Event pulses
	assign events[`UFC_EV_RX_THR]   = rx_req & ~rx_req_d;
	assign events[`UFC_EV_RX_TMO]   = rx_timeout_i;
	assign events[`UFC_EV_TX_EMPTY] = txq.empty & ~tx_empty_d;
	assign events[`UFC_EV_RX_OVF]   = rx_push_i & rxq.full;
	assign w1c = (bus_wr && hit_istat && lane0) ?
	             wb_dat_i[`UFC_EV_W-1:0] : '0;

	// Sticky status, a new event beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_stat   <= '0;
			int_mask   <= '0;
			rx_req_d   <= 1'b0;
			tx_empty_d <= 1'b1;
		end else begin
			int_stat   <= (int_stat & ~w1c) | events;
			rx_req_d   <= rx_req;
			tx_empty_d <= txq.empty;
			if (bus_wr && hit_imask && lane0)
				int_mask <= wb_dat_i[`UFC_EV_W-1:0];
		end
	end

	assign irq_o = |(int_stat & int_mask);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Register words
	assign rx_word     = {23'h00_0000, ~rxq.empty, rxq.pop_data};
	assign status_word = {12'h000,
	                      rx_req, rx_dma_ready_n_o,
	                      tx_dma_ready_n_o, fifo_en,
	                      cnt_byte(txq.count),
	                      cnt_byte(rxq.count)};
	assign rd_word = hit_data  ? rx_word :
	                 hit_fc    ? {24'h00_0000, fifo_control} :
	                 hit_stat  ? status_word :
	                 hit_istat ? 32'(int_stat) :
	                 hit_imask ? 32'(int_mask) : 32'h0000_0000;

	// Read data captured as ack rises, held with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o    <= 32'h0000_0000;
			rd_had_data <= 1'b0;
		end else if (bus_req && !wb_ack) begin
			wb_dat_o    <= wb_we_i ? 32'h0000_0000 : rd_word;
			rd_had_data <= ~rxq.empty;
		end
	end
endmodule

/* tb/ufc_line_model.sv */
// Serial side model: receiver pushes, time-outs, transmitter pops
`timescale 1ns/1ps

module ufc_line_model (
	// Clock
	input  wire logic  clk_i,
	// Receiver strobes
	output logic       rx_push_o,
	output logic [7:0] rx_data_o,
	output logic       rx_timeout_o,
	// Transmitter strobe
	output logic       tx_pop_o
);
	// Idle lines at time zero
	initial begin
		rx_push_o = 1'b0;
		rx_data_o = 8'h00;
		rx_timeout_o = 1'b0;
		tx_pop_o = 1'b0;
	end

	// Push n characters back to back: d, d+1, ...
	task automatic send(input int n, input logic [7:0] d);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			rx_push_o <= 1'b1;
			rx_data_o <= d + i[7:0];
		end
		@(posedge clk_i);
		rx_push_o <= 1'b0;
		// No stale character left on the line
		rx_data_o <= ~rx_data_o;
	endtask

	// One time-out pulse, or one transmitter pop
	task automatic strobe(input logic tmo);
		@(posedge clk_i);
		if (tmo)
			rx_timeout_o <= 1'b1;
		else
			tx_pop_o <= 1'b1;
		@(posedge clk_i);
		rx_timeout_o <= 1'b0;
		tx_pop_o <= 1'b0;
	endtask
endmodule

/* tb/ufc_top_monitor.sv */
// Port checker for the FIFO control block
`timescale 1ns/1ps

module ufc_top_monitor #(
	parameter int DEPTH = 16,
	parameter int CW    = 5
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Register bus
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	input  wire logic [31:0]   wb_dat_o,
	input  wire logic          wb_ack_o,
	// Queues and pins
	input  wire logic          rx_push_i,
	input  wire logic [CW-1:0] tx_count_o,
	input  wire logic [CW-1:0] rx_count_o,
	input  wire logic          rx_irq_req_o,
	input  wire logic          tx_dma_ready_n_o,
	input  wire logic          rx_dma_ready_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Control register accesses at the ack edge
	wire ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h04;
	wire ctl_rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h04;

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ctl_unused: assert property (ctl_rd |->
		wb_dat_o[5:4] == 2'b00 && wb_dat_o[2:1] == 2'b00)
		else $error("unused or clear bits read back set");
	a_tx_clear: assert property (ctl_wr && wb_dat_i[2] |-> ##2 tx_count_o == '0)
		else $error("transmit queue not emptied");
	a_rx_clear: assert property (ctl_wr && wb_dat_i[1] |-> ##2 rx_count_o == '0)
		else $error("receive queue not emptied");
	a_rx_fill: assert property (rx_push_i && rx_count_o == '0 && !wb_cyc_i &&
		!$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |=> rx_count_o == 1)
		else $error("receive push not stored");
	a_req_none: assert property (rx_count_o == '0 |-> !rx_irq_req_o)
		else $error("receive request with empty queue");
	a_req_top: assert property (rx_count_o >= 14 |-> rx_irq_req_o)
		else $error("receive request missing at top level");
	a_tx_empty: assert property (tx_count_o == '0 |=> !tx_dma_ready_n_o)
		else $error("transmit ready high while empty");
	a_tx_full: assert property (tx_count_o == DEPTH |=> tx_dma_ready_n_o)
		else $error("transmit ready low while full");
	a_rx_empty: assert property (rx_count_o == '0 |=> rx_dma_ready_n_o)
		else $error("receive ready low while empty");

	// Main scenarios reached
	c_req_rise: cover property ($rose(rx_irq_req_o));
	c_tx_full: cover property (tx_count_o == DEPTH);
	c_rx_ready: cover property ($fell(rx_dma_ready_n_o));
endmodule

/* tb/ufc_top_test.sv */
// Self-checking bench for the FIFO control block
`timescale 1ns/1ps

module ufc_top_test;
	import ufc_pkg::*;
	// Bench signals
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        tx_pop_i, tx_valid_o, rx_push_i, rx_timeout_i, irq_o;
	logic        rx_irq_req_o, tx_dma_ready_n_o, rx_dma_ready_n_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [4:0]  tx_count_o, rx_count_o;
	ufc_char_t   tx_data_o, rx_data_i;
	int          n_fail, checked, t;

	ufc_top #(.DEPTH(16)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_pop_i(tx_pop_i), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_count_o(tx_count_o),
		.rx_push_i(rx_push_i), .rx_data_i(rx_data_i),
		.rx_timeout_i(rx_timeout_i), .rx_count_o(rx_count_o),
		.rx_irq_req_o(rx_irq_req_o), .tx_dma_ready_n_o(tx_dma_ready_n_o),
		.rx_dma_ready_n_o(rx_dma_ready_n_o), .irq_o(irq_o)
	);
	ufc_line_model i_line (
		.clk_i(clk_i), .rx_push_o(rx_push_i), .rx_data_o(rx_data_i),
		.rx_timeout_o(rx_timeout_i), .tx_pop_o(tx_pop_i)
	);

	// Clock
	initial clk_i = 1'b0;
	always #5 clk_i = ~clk_i;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One classic cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'h1;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		// Answer lands one cycle after the request is taken
		ck("ack delay", 2, n);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0000_0000);
		ck(nm, e, q);
	endtask

	// Let n edges land, then look between edges
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0000_0000;
		n_fail = 0;
		checked = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		w(1);
		rd(8'h04, 32'h0000_0000, "fifo_control");
		ck("tx_ready_n", 0, tx_dma_ready_n_o);
		ck("rx_ready_n", 1, rx_dma_ready_n_o);
		rd(8'h40, 32'h0000_0000, "unmapped");
		wr(8'h10, 32'h0000_0001);
		i_line.send(2, 8'h30);
		w(3);
		ck("rx_count", 1, rx_count_o);
		ck("rx_ready_n", 0, rx_dma_ready_n_o);
		ck("irq", 1, irq_o);
		rd(8'h00, 32'h0000_0130, "rx_data");
		w(3);
		ck("rx_ready_n", 1, rx_dma_ready_n_o);
		wr(8'h0C, 32'h0000_000F);
		wr(8'h10, 32'h0000_0000);
		ck("irq", 0, irq_o);
		wr(8'h00, 32'h0000_0055);
		w(3);
		ck("tx_data", 8'h55, tx_data_o);
		ck("tx_valid", 1, tx_valid_o);
		ck("tx_ready_n", 1, tx_dma_ready_n_o);
		i_line.strobe(1'b0);
		w(3);
		ck("tx_ready_n", 0, tx_dma_ready_n_o);
		ck("tx_valid", 0, tx_valid_o);
		// Every threshold code in mode 1
		for (int s = 0; s < 4; s++) begin
			t = (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
			wr(8'h04, {s[1:0], 6'h0F});
			w(3);
			i_line.send(t - 1, 8'h00);
			w(3);
			ck("rx_req", 0, rx_irq_req_o);
			ck("rx_ready_n", 1, rx_dma_ready_n_o);
			i_line.send(1, 8'h77);
			w(3);
			ck("rx_req", 1, rx_irq_req_o);
			ck("rx_ready_n", 0, rx_dma_ready_n_o);
			rd(8'h00, (t == 1) ? 32'h0000_0177 : 32'h0000_0100, "rx_data");
			w(3);
			ck("rx_req", 0, rx_irq_req_o);
			ck("rx_ready_n", (t == 1) ? 1 : 0, rx_dma_ready_n_o);
			wr(8'h04, {s[1:0], 6'h0B});
			w(3);
			ck("rx_count", 0, rx_count_o);
			ck("rx_ready_n", 1, rx_dma_ready_n_o);
			rd(8'h04, {s[1:0], 6'h09}, "fifo_control");
		end
		i_line.send(17, 8'h40);
		w(3);
		ck("rx_count", 16, rx_count_o);
		wr(8'h04, 32'h0000_00CB);
		i_line.send(1, 8'h20);
		w(3);
		ck("rx_ready_n", 1, rx_dma_ready_n_o);
		i_line.strobe(1'b1);
		w(3);
		ck("rx_ready_n", 0, rx_dma_ready_n_o);
		for (int i = 0; i < 16; i++)
			wr(8'h00, i);
		w(3);
		ck("tx_ready_n", 1, tx_dma_ready_n_o);
		i_line.strobe(1'b0);
		w(3);
		ck("tx_ready_n", 0, tx_dma_ready_n_o);
		wr(8'h04, 32'h0000_00CD);
		w(3);
		ck("tx_count", 0, tx_count_o);
		wr(8'h04, 32'h0000_0031);
		wr(8'h00, 32'h0000_0066);
		w(3);
		ck("tx_ready_n", 1, tx_dma_ready_n_o);
		ck("rx_ready_n", 0, rx_dma_ready_n_o);
		ck("irq", 0, irq_o);
		rd(8'h08, 32'h000B_0101, "status");
		rd(8'h04, 32'h0000_0001, "fifo_control");
		wr(8'h10, 32'h0000_0001);
		w(1);
		ck("irq", 1, irq_o);
		rd(8'h10, 32'h0000_0001, "int_mask");
		wr(8'h0C, 32'h0000_0001);
		w(1);
		ck("irq", 0, irq_o);
		rd(8'h0C, 32'h0000_000E, "int_status");
		complete_run();
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
endmodule

bind ufc_top ufc_top_monitor #(.DEPTH(DEPTH), .CW(CW)) i_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.rx_push_i(rx_push_i), .tx_count_o(tx_count_o), .rx_count_o(rx_count_o),
	.rx_irq_req_o(rx_irq_req_o), .tx_dma_ready_n_o(tx_dma_ready_n_o),
	.rx_dma_ready_n_o(rx_dma_ready_n_o)
);
